// file: src/return_and_rotate_exec.sv
// Execution datapath for return and left/plain-right rotate instructions.
`timescale 1ns/1ps
module return_and_rotate_exec (
  input  wire logic        clock_in,          // System clock, 20 MHz.
  input  wire logic        rst_b_in,          // Asynchronous reset, active low.
  input  wire logic        clk_en_in,         // Freezes all state while low.
  input  wire logic        exec_valid_in,     // One-cycle strobe: execute operation.
  input  wire logic [2:0]  exec_op_in,        // Operation code.
  input  wire logic [7:0]  imm_in,            // Immediate byte of the instruction.
  input  wire logic [7:0]  mem_rd_in,         // Addressed data-memory byte.
  input  wire logic        carry_in,          // Present carry flag.
  input  wire logic [15:0] stack_top_in,      // Address at the top of the stack.
  input  wire logic        irq_pending_in,    // An interrupt request is pending.
  output logic             done_out,          // One-cycle pulse: results valid.
  output logic             stack_pop_out,     // One-cycle pulse: pop the stack.
  output logic             pc_load_out,       // One-cycle pulse: load the PC.
  output logic [15:0]      pc_value_out,      // New program counter.
  output logic             acc_we_out,        // One-cycle pulse: write accumulator.
  output logic [7:0]       acc_value_out,     // Accumulator value.
  output logic             mem_we_out,        // One-cycle pulse: write memory.
  output logic [7:0]       mem_value_out,     // Memory write value.
  output logic             carry_we_out,      // One-cycle pulse: write carry.
  output logic             carry_value_out,   // Carry value.
  output logic             master_irq_enable_set_out, // Pulse: set master enable.
  output logic             irq_take_out       // Pulse: enter pending interrupt now.
);

  // ******************************************************************
  // State registers.
  // ******************************************************************

  // Present and next state of the whole block.
  ret_rot_pkg::exec_state_t st_ff;
  ret_rot_pkg::exec_state_t nxt_st;

  // Left rotate of a byte by one, with a chosen bit shifted in at bit 0.
  function automatic logic [7:0] rotl(input logic [7:0] b, input logic in0);
    rotl = {b[6:0], in0};
  endfunction

  // ******************************************************************
  // Next-state logic.
  // ******************************************************************

  // Decodes one operation and forms every write strobe and value.
  always_comb begin
    nxt_st = st_ff;
    // Strobes last exactly one cycle.
    nxt_st.done       = 1'b0;
    nxt_st.stack_pop  = 1'b0;
    nxt_st.pc_load    = 1'b0;
    nxt_st.acc_we     = 1'b0;
    nxt_st.mem_we     = 1'b0;
    nxt_st.carry_we   = 1'b0;
    nxt_st.irq_en_set = 1'b0;
    nxt_st.irq_take   = 1'b0;
    nxt_st.state      = ret_rot_pkg::ST_RUN;
    if (exec_valid_in) begin
      nxt_st.done = 1'b1;
      unique case (exec_op_in)
        ret_rot_pkg::OP_RET_IMM: begin
          // Pop address and load immediate; no flag is written.
          nxt_st.stack_pop = 1'b1;
          nxt_st.pc_load   = 1'b1;
          nxt_st.pc_value  = stack_top_in;
          nxt_st.acc_we    = 1'b1;
          nxt_st.acc_value = imm_in;
        end
        ret_rot_pkg::OP_RET_IRQ: begin
          // Pop address and re-enable interrupts.
          nxt_st.stack_pop  = 1'b1;
          nxt_st.pc_load    = 1'b1;
          nxt_st.pc_value   = stack_top_in;
          nxt_st.irq_en_set = 1'b1;
          // A pending request is entered before the main program resumes.
          nxt_st.irq_take   = irq_pending_in;
          if (irq_pending_in) begin
            nxt_st.state = ret_rot_pkg::ST_IRQ;
          end
        end
        ret_rot_pkg::OP_ROL_MEM: begin
          // Rotate in place, bit 7 wraps to bit 0.
          nxt_st.mem_we    = 1'b1;
          nxt_st.mem_value = rotl(mem_rd_in, mem_rd_in[7]);
        end
        ret_rot_pkg::OP_ROL_ACC: begin
          // Result goes to the accumulator only.
          nxt_st.acc_we    = 1'b1;
          nxt_st.acc_value = rotl(mem_rd_in, mem_rd_in[7]);
        end
        ret_rot_pkg::OP_ROLC_MEM: begin
          // Old carry enters bit 0, old bit 7 becomes carry.
          nxt_st.mem_we      = 1'b1;
          nxt_st.mem_value   = rotl(mem_rd_in, carry_in);
          nxt_st.carry_we    = 1'b1;
          nxt_st.carry_value = mem_rd_in[7];
        end
        ret_rot_pkg::OP_ROLC_ACC: begin
          // Same rotate, but accumulator gets the result.
          nxt_st.acc_we      = 1'b1;
          nxt_st.acc_value   = rotl(mem_rd_in, carry_in);
          nxt_st.carry_we    = 1'b1;
          nxt_st.carry_value = mem_rd_in[7];
        end
        ret_rot_pkg::OP_ROR_MEM: begin
          // Rotate right in place, bit 0 wraps to bit 7.
          nxt_st.mem_we    = 1'b1;
          nxt_st.mem_value = {mem_rd_in[0], mem_rd_in[7:1]};
        end
        default: begin
          // Codes outside this block are ignored.
          nxt_st.done = 1'b0;
        end
      endcase
    end
  end

  // Registers the state; the clock enable holds everything still.
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff             <= '0;
      st_ff.state       <= ret_rot_pkg::ST_RUN;
      st_ff.pc_value    <= ret_rot_pkg::PC_RST;
      st_ff.acc_value   <= ret_rot_pkg::BYTE_RST;
      st_ff.mem_value   <= ret_rot_pkg::BYTE_RST;
    end else if (clk_en_in) begin
      st_ff <= nxt_st;
    end
  end

  // ******************************************************************
  // Outputs.
  // ******************************************************************

  // All outputs come straight from flip-flops.
  assign done_out                  = st_ff.done;
  assign stack_pop_out             = st_ff.stack_pop;
  assign pc_load_out               = st_ff.pc_load;
  assign pc_value_out              = st_ff.pc_value;
  assign acc_we_out                = st_ff.acc_we;
  assign acc_value_out             = st_ff.acc_value;
  assign mem_we_out                = st_ff.mem_we;
  assign mem_value_out             = st_ff.mem_value;
  assign carry_we_out              = st_ff.carry_we;
  assign carry_value_out           = st_ff.carry_value;
  assign master_irq_enable_set_out = st_ff.irq_en_set;
  assign irq_take_out              = st_ff.irq_take;

  // ******************************************************************
  // Assertions.
  // ******************************************************************

  // Every property below samples on the system clock and sleeps during reset.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  // Return with immediate: pop, load PC and accumulator, leave carry alone.
  ret_imm_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h0 |=>
    stack_pop_out && pc_load_out && pc_value_out == $past(stack_top_in) &&
    acc_we_out && acc_value_out == $past(imm_in) && !carry_we_out && !mem_we_out)
    else $error("return immediate wrong");

  // Return from interrupt: pop, load PC, set the master enable, leave carry alone.
  ret_irq_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h1 |=>
    stack_pop_out && pc_load_out && pc_value_out == $past(stack_top_in) &&
    master_irq_enable_set_out && !carry_we_out && !acc_we_out)
    else $error("return from interrupt wrong");

  // A request pending at the return is entered at once, and only then.
  irq_take_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h1 |=>
    irq_take_out == $past(irq_pending_in))
    else $error("pending interrupt not taken");

  // The interrupt-entry state only ever sits on the cycle of a return.
  irq_seq_a: assert property (st_ff.state == ret_rot_pkg::ST_IRQ |->
    irq_take_out && pc_load_out && master_irq_enable_set_out)
    else $error("interrupt entry without return");

  // Plain left rotate in memory: bit 7 wraps to bit 0, no flag written.
  rol_mem_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h2 |=>
    mem_we_out && !acc_we_out && !carry_we_out &&
    mem_value_out == {$past(mem_rd_in[6:0]), $past(mem_rd_in[7])})
    else $error("rotate left memory wrong");

  // Left rotate into the accumulator: memory and flags untouched.
  rol_acc_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h3 |=>
    acc_we_out && !mem_we_out && !carry_we_out &&
    acc_value_out == {$past(mem_rd_in[6:0]), $past(mem_rd_in[7])})
    else $error("rotate left to acc wrong");

  // Left rotate through carry in memory: old carry in at bit 0, bit 7 out to carry.
  rolc_mem_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h4 |=>
    mem_we_out && carry_we_out && !acc_we_out &&
    mem_value_out == {$past(mem_rd_in[6:0]), $past(carry_in)} &&
    carry_value_out == $past(mem_rd_in[7]))
    else $error("rotate through carry wrong");

  // Left rotate through carry into the accumulator: memory left alone.
  rolc_acc_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h5 |=>
    acc_we_out && carry_we_out && !mem_we_out &&
    acc_value_out == {$past(mem_rd_in[6:0]), $past(carry_in)} &&
    carry_value_out == $past(mem_rd_in[7]))
    else $error("rotate through carry to acc wrong");

  // Plain right rotate in memory: bit 0 wraps to bit 7, no flag written.
  ror_mem_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h6 |=>
    mem_we_out && !acc_we_out && !carry_we_out &&
    mem_value_out == {$past(mem_rd_in[0]), $past(mem_rd_in[7:1])})
    else $error("rotate right memory wrong");

  // Codes outside the block raise no strobe at all.
  op_refused_a: assert property (clk_en_in && exec_valid_in && exec_op_in == 3'h7 |=>
    !done_out && !stack_pop_out && !pc_load_out && !acc_we_out && !mem_we_out && !carry_we_out)
    else $error("unused code not ignored");

  // While the clock enable is low the whole state holds, strobes included.
  freeze_hold_a: assert property (!clk_en_in |=> $stable(st_ff))
    else $error("state moved while frozen");

  // Main scenarios that the bench must reach.
  ret_imm_c: cover property (clk_en_in && exec_valid_in && exec_op_in == 3'h0);
  ret_irq_c: cover property (clk_en_in && exec_valid_in && exec_op_in == 3'h1 && irq_pending_in);
  rolc_c:    cover property (clk_en_in && exec_valid_in && exec_op_in == 3'h4 && carry_in);
  ror_c:     cover property (clk_en_in && exec_valid_in && exec_op_in == 3'h6 && mem_rd_in[0]);
  freeze_c:  cover property (!clk_en_in && exec_valid_in);

endmodule

// file: src/ret_rot_pkg.sv
// Constants and types shared by the return and rotate execution block.
// Function
// - Return-immediate pops PC, loads accumulator, flags kept
// - Return-from-interrupt pops PC, sets master enable
// - Pending interrupt served before resuming main program
// - Rotate left memory, bit7 to bit0, flags kept
// - Rotate left into accumulator, memory and flags kept
// - Rotate left through carry, write back memory
// - Rotate left through carry into accumulator only
// - Rotate right memory, bit0 to bit7, flags kept
package ret_rot_pkg;

  // ******************************************************************
  // Widths and operation codes.
  // ******************************************************************

  // Width of data bytes.
  localparam int unsigned DATA_W = 8;
  // Width of the program counter.
  localparam int unsigned PC_W = 16;
  // Width of the operation select field.
  localparam int unsigned OP_W = 3;

  // Operation codes presented by the decoder.
  localparam logic [2:0] OP_RET_IMM   = 3'h0;
  localparam logic [2:0] OP_RET_IRQ   = 3'h1;
  localparam logic [2:0] OP_ROL_MEM   = 3'h2;
  localparam logic [2:0] OP_ROL_ACC   = 3'h3;
  localparam logic [2:0] OP_ROLC_MEM  = 3'h4;
  localparam logic [2:0] OP_ROLC_ACC  = 3'h5;
  localparam logic [2:0] OP_ROR_MEM   = 3'h6;

  // ******************************************************************
  // Values after reset.
  // ******************************************************************

  // Reset value of byte outputs.
  localparam logic [7:0]  BYTE_RST = 8'h00;
  // Reset value of program counter output.
  localparam logic [15:0] PC_RST   = 16'h0000;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_IRQ = 2'h2
  } seq_state_t;

  // Complete registered state of the block.
  typedef struct packed {
    seq_state_t  state;
    logic        done;
    logic        stack_pop;
    logic        pc_load;
    logic [15:0] pc_value;
    logic        acc_we;
    logic [7:0]  acc_value;
    logic        mem_we;
    logic [7:0]  mem_value;
    logic        carry_we;
    logic        carry_value;
    logic        irq_en_set;
    logic        irq_take;
  } exec_state_t;

endpackage

// file: testbench/return_and_rotate_exec_tb.sv
// Self-checking testbench for the return and rotate execution block.
`timescale 1ns/1ps
module return_and_rotate_exec_tb;
  // ******************************************************************
  // Signals, expectations and counters.
  // ******************************************************************
  logic        clock_in = 1'b0; // Starts low, so no edge is seen at time zero.
  logic        rst_b_in, clk_en_in, exec_valid_in, carry_in, irq_pending_in;
  logic [2:0]  exec_op_in;       // Operation code driven to the block.
  logic [7:0]  imm_in, mem_rd_in; // Immediate and memory bytes.
  logic [15:0] stack_top_in;     // Stack top address.
  logic        done_out, stack_pop_out, pc_load_out, acc_we_out, mem_we_out;
  logic        carry_we_out, carry_value_out, master_irq_enable_set_out, irq_take_out;
  logic [15:0] pc_value_out;     // Program counter from the block.
  logic [7:0]  acc_value_out, mem_value_out; // Byte results from the block.
  logic [39:0] exp_q[$];         // Expected output words, oldest first.
  logic [39:0] seen;             // Output word seen at the last check.
  logic [39:0] exp_w;            // Output word expected at the last check.
  logic [15:0] e_pc;             // Program counter the block should hold.
  logic [7:0]  e_acc, e_mem;     // Byte values the block should hold.
  logic        e_c;              // Carry value the block should hold.
  int          failures, checks, cycles;

  return_and_rotate_exec dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .exec_valid_in(exec_valid_in), .exec_op_in(exec_op_in), .imm_in(imm_in),
    .mem_rd_in(mem_rd_in), .carry_in(carry_in), .stack_top_in(stack_top_in),
    .irq_pending_in(irq_pending_in), .done_out(done_out), .stack_pop_out(stack_pop_out),
    .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .acc_we_out(acc_we_out),
    .acc_value_out(acc_value_out), .mem_we_out(mem_we_out), .mem_value_out(mem_value_out),
    .carry_we_out(carry_we_out), .carry_value_out(carry_value_out),
    .master_irq_enable_set_out(master_irq_enable_set_out), .irq_take_out(irq_take_out));

  // Free-running 20 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // Compares one value, counts it and reports a mismatch.
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Presents one operation and notes the outputs it should produce.
  task automatic issue(input logic [2:0] op, input logic [7:0] m, input logic c, input logic p);
    logic [7:0]  im;
    logic [15:0] st;
    logic        pop, aw, mw, cw, ie;
    im = 8'($urandom);
    st = 16'($urandom);
    {pop, aw, mw, cw, ie} = '0;
    @(posedge clock_in);
    #1;
    {exec_valid_in, exec_op_in, mem_rd_in, carry_in, irq_pending_in} = {1'b1, op, m, c, p};
    {imm_in, stack_top_in} = {im, st};
    // Flags other than carry are never touched, so only rotates through carry write it.
    case (op)
      ret_rot_pkg::OP_RET_IMM:  {pop, e_pc, aw, e_acc} = {1'b1, st, 1'b1, im};
      ret_rot_pkg::OP_RET_IRQ:  {pop, e_pc, ie} = {1'b1, st, 1'b1};
      ret_rot_pkg::OP_ROL_MEM:  {mw, e_mem} = {1'b1, m[6:0], m[7]};
      ret_rot_pkg::OP_ROL_ACC:  {aw, e_acc} = {1'b1, m[6:0], m[7]};
      ret_rot_pkg::OP_ROLC_MEM: {mw, e_mem, cw, e_c} = {1'b1, m[6:0], c, 1'b1, m[7]};
      ret_rot_pkg::OP_ROLC_ACC: {aw, e_acc, cw, e_c} = {1'b1, m[6:0], c, 1'b1, m[7]};
      ret_rot_pkg::OP_ROR_MEM:  {mw, e_mem} = {1'b1, m[0], m[7:1]};
      default: ;
    endcase
    if (op != 3'h7) exp_q.push_back({pop, pop, e_pc, aw, e_acc, mw, e_mem, cw, e_c, ie, ie & p});
  endtask

  // Drops the execute strobe for one cycle.
  task automatic idle();
    @(posedge clock_in);
    #1;
    exec_valid_in = 1'b0;
  endtask

  // Watches the outputs at mid-cycle; strobes must be low whenever done is.
  always @(negedge clock_in) begin
    seen = {stack_pop_out, pc_load_out, pc_value_out, acc_we_out, acc_value_out, mem_we_out,
            mem_value_out, carry_we_out, carry_value_out, master_irq_enable_set_out, irq_take_out};
    if (done_out === 1'b1) begin
      // A result with no note behind it is compared against its own inverse.
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
      chk("outputs", exp_w, seen);
    end else begin
      chk("idle strobes", 40'h0, (seen & 40'hc0_0020_100b) | {39'h0, done_out});
    end
  end

  // Cuts a hang short.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end

  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    void'($urandom(60891));
    {rst_b_in, exec_valid_in, exec_op_in, imm_in, mem_rd_in, carry_in} = '0;
    {stack_top_in, irq_pending_in, e_pc, e_acc, e_mem, e_c} = '0;
    clk_en_in = 1'b1;
    repeat (5) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    issue(ret_rot_pkg::OP_RET_IMM, 8'h5a, 1'b1, 1'b1);
    issue(ret_rot_pkg::OP_RET_IRQ, 8'h00, 1'b0, 1'b1);
    issue(ret_rot_pkg::OP_RET_IRQ, 8'hff, 1'b1, 1'b0);
    issue(ret_rot_pkg::OP_ROL_MEM, 8'h80, 1'b0, 1'b0);
    issue(ret_rot_pkg::OP_ROL_ACC, 8'h81, 1'b1, 1'b0);
    issue(ret_rot_pkg::OP_ROLC_MEM, 8'h80, 1'b1, 1'b0);
    issue(ret_rot_pkg::OP_ROLC_MEM, 8'h7f, 1'b0, 1'b0);
    issue(ret_rot_pkg::OP_ROLC_ACC, 8'h80, 1'b0, 1'b0);
    issue(ret_rot_pkg::OP_ROLC_ACC, 8'h01, 1'b1, 1'b0);
    issue(ret_rot_pkg::OP_ROR_MEM, 8'h01, 1'b1, 1'b0);
    issue(3'h7, 8'h33, 1'b1, 1'b1);
    idle();
    // A request held while the clock enable is low must not be taken.
    @(posedge clock_in);
    #1;
    {clk_en_in, exec_valid_in, exec_op_in} = {1'b0, 1'b1, ret_rot_pkg::OP_ROLC_MEM};
    repeat (3) @(posedge clock_in);
    #1;
    {clk_en_in, exec_valid_in} = 2'b10;
    for (int i = 0; i < 300; i++) begin
      issue(3'($urandom), 8'($urandom), 1'($urandom), 1'($urandom));
      if ($urandom % 4 == 0) idle();
    end
    idle();
    repeat (2) @(posedge clock_in);
    // A second reset in mid-run clears the held values.
    #1;
    rst_b_in = 1'b0;
    {e_pc, e_acc, e_mem, e_c} = '0;
    repeat (2) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    issue(ret_rot_pkg::OP_ROL_MEM, 8'h55, 1'b0, 1'b0);
    idle();
    repeat (3) @(posedge clock_in);
    chk("pending results", 40'h0, 40'(exp_q.size()));
    results();
  end
endmodule
